// ==== logic/timer8_pkg.sv ====
package timer8_pkg;

  // Register addresses on the plain register port
  localparam logic [3:0] ADDR_CONTROL_A = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B = 4'h1;
  localparam logic [3:0] ADDR_COUNTER   = 4'h2;
  localparam logic [3:0] ADDR_COMPARE_A = 4'h3;
  localparam logic [3:0] ADDR_COMPARE_B = 4'h4;
  localparam logic [3:0] ADDR_MASK      = 4'h5;
  localparam logic [3:0] ADDR_FLAG      = 4'h6;

  // Field positions
  localparam int WGM_LO_POS   = 0;
  localparam int COM_B_POS    = 4;
  localparam int COM_A_POS    = 6;
  localparam int CS_POS       = 0;
  localparam int WGM_HI_POS   = 3;
  localparam int FORCE_B_POS  = 6;
  localparam int FORCE_A_POS  = 7;
  localparam int OVF_POS      = 0;
  localparam int MATCH_A_POS  = 1;
  localparam int MATCH_B_POS  = 2;

  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // Waveform modes
  localparam logic [2:0] WGM_NORMAL     = 3'h0;
  localparam logic [2:0] WGM_PC_MAX     = 3'h1;
  localparam logic [2:0] WGM_CTC        = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX   = 3'h3;
  localparam logic [2:0] WGM_PC_OCRA    = 3'h5;
  localparam logic [2:0] WGM_FAST_OCRA  = 3'h7;

  // Clock selects
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Compare output modes
  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Per-channel compare context
  typedef struct packed {
    logic       match;
    logic       force_hit;
    logic [1:0] mode;
  } cmp_ctx_t;

endpackage : timer8_pkg

// ==== logic/compare_output_unit.sv ====
`timescale 1ns/10ps
module compare_output_unit (
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  // Timing context
  input  wire logic                   i_tick,
  input  wire logic                   i_pwm,
  input  wire logic                   i_fast,
  input  wire logic                   i_up,
  input  wire logic                   i_at_bottom,
  input  wire logic                   i_at_top,
  input  wire timer8_pkg::cmp_ctx_t   i_ctx,
  // Output state
  output logic                        o_level
);
  import timer8_pkg::*;

  typedef struct packed {
    logic level;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_ctx.mode != COM_NONE) begin
      if (!i_pwm) begin
        if ((i_tick && i_ctx.match) || i_ctx.force_hit) begin
          unique case (i_ctx.mode)
            COM_TOGGLE: st_nxt.level = ~st_r.level;
            COM_CLEAR:  st_nxt.level = 1'b0;
            default:    st_nxt.level = 1'b1;
          endcase
        end
      end else if (i_tick && i_ctx.mode[1]) begin
        // Inverting when low mode bit set
        if (i_fast) begin
          if (i_ctx.match) begin
            st_nxt.level = i_ctx.mode[0];
          end else if (i_at_bottom) begin
            st_nxt.level = ~i_ctx.mode[0];
          end
        end else if (i_ctx.match) begin
          st_nxt.level = i_up ? i_ctx.mode[0] : ~i_ctx.mode[0];
        end else if (i_at_top && !i_ctx.match) begin
          st_nxt.level = st_r.level;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.level;

endmodule : compare_output_unit

// ==== logic/timer8_counter_compare_core.sv ====
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - Counter and both compare values are 8 bits, compared by 8-bit comparators.
// - Overflow, match A, match B flags in one register, each maskable.
// - Clock select picks prescaled or external pin edge; zero stops counter.
// - Software may read and write the counter at any time.
// - Software counter write beats any clear or count in that cycle.
// - Each tick clears, increments or decrements counter per mode and direction.
// - 0x00 is bottom, 0xFF is maximum; bottom and top, not maximum, go to waveform logic.
// - Top is 0xFF or compare value A depending on mode.
// - Three-bit waveform mode: two low bits in control A, high bit in B.
// - Overflow flag set per mode and can raise an interrupt.
// - Equal compare sets its flag at next tick and requests interrupt if enabled.
// - Match flags clear on interrupt service or by writing one.
// - Compare output formed from match, waveform mode, output mode, top, bottom.
// - PWM modes double buffer compare values, updated at top in both fast and phase correct modes.
// - Buffered: software reaches buffer; unbuffered: the active compare value.
// - Force strobe in non-PWM modes updates output only, no flag, no clear.
// - Counter write blocks compare matches for the next tick, even stopped.
// - Normal mode counts up, wraps 0xFF to 0x00, overflow at zero.
// - Clear-on-match mode clears counter when it equals compare value A.
// - Compare output states reset to zero; output mode zero means no action.
module timer8_counter_compare_core (
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_reset,
  // Register port
  input  wire timer8_pkg::reg_req_t i_req,
  output logic [7:0]                o_rdata,
  // Tick sources
  input  wire logic                 i_prescaled_tick,
  input  wire logic                 i_external_count_pin,
  // Interrupt service acknowledges
  input  wire logic                 i_ack_overflow,
  input  wire logic                 i_ack_match_a,
  input  wire logic                 i_ack_match_b,
  // Outputs
  output logic                      o_irq_overflow,
  output logic                      o_irq_match_a,
  output logic                      o_irq_match_b,
  output logic                      o_compare_output_a,
  output logic                      o_compare_output_b,
  output logic                      o_compare_output_en_a,
  output logic                      o_compare_output_en_b
);
  import timer8_pkg::*;

  typedef struct packed {
    logic [7:0] timer_control_a;
    logic [2:0] clock_select;
    logic       waveform_mode_bit2;
    logic [7:0] counter_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] buffer_a;
    logic [7:0] buffer_b;
    logic [2:0] timer_mask_reg;
    logic       overflow_flag;
    logic       match_flag_a;
    logic       match_flag_b;
    logic       count_down;
    logic       block_match;
    logic       pin_meta;
    logic       pin_sync;
    logic       pin_prev;
    logic [7:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [2:0] waveform_mode;
  logic       pwm_mode;
  logic       fast_mode;
  logic       top_is_a;
  logic [7:0] top_value;
  logic       at_bottom;
  logic       at_max;
  logic       at_top;
  logic       timer_tick;
  logic       match_a;
  logic       match_b;
  logic       write_counter;
  logic       force_a;
  logic       force_b;
  logic       ovf_set;
  cmp_ctx_t   ctx_a;
  cmp_ctx_t   ctx_b;

  // Mode decode
  assign waveform_mode = {st_r.waveform_mode_bit2,
                          st_r.timer_control_a[WGM_LO_POS+1 -: 2]};
  assign pwm_mode  = (waveform_mode != WGM_NORMAL) && (waveform_mode != WGM_CTC);
  assign fast_mode = (waveform_mode == WGM_FAST_MAX) || (waveform_mode == WGM_FAST_OCRA);
  assign top_is_a  = (waveform_mode == WGM_CTC) || (waveform_mode == WGM_PC_OCRA) ||
                     (waveform_mode == WGM_FAST_OCRA);
  assign top_value = top_is_a ? st_r.compare_value_a : COUNT_MAX;
  assign at_bottom = (st_r.counter_value == COUNT_BOTTOM);
  assign at_max    = (st_r.counter_value == COUNT_MAX);
  assign at_top    = (st_r.counter_value == top_value);

  // Tick select; external pin edges seen only after two-stage sync
  always_comb begin
    unique case (st_r.clock_select)
      CS_STOP:     timer_tick = 1'b0;
      CS_EXT_FALL: timer_tick = st_r.pin_prev & ~st_r.pin_sync;
      CS_EXT_RISE: timer_tick = ~st_r.pin_prev & st_r.pin_sync;
      default:     timer_tick = i_prescaled_tick;
    endcase
  end

  // Comparators, blocked for one tick after counter write
  assign match_a = (st_r.counter_value == st_r.compare_value_a) && !st_r.block_match;
  assign match_b = (st_r.counter_value == st_r.compare_value_b) && !st_r.block_match;

  assign write_counter = i_req.we && (i_req.addr == ADDR_COUNTER);
  assign force_a = i_req.we && (i_req.addr == ADDR_CONTROL_B) && i_req.wdata[FORCE_A_POS] && !pwm_mode;
  assign force_b = i_req.we && (i_req.addr == ADDR_CONTROL_B) && i_req.wdata[FORCE_B_POS] && !pwm_mode;

  assign ctx_a = '{match: match_a, force_hit: force_a,
                   mode: st_r.timer_control_a[COM_A_POS+1 -: 2]};
  assign ctx_b = '{match: match_b, force_hit: force_b,
                   mode: st_r.timer_control_a[COM_B_POS+1 -: 2]};

  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_meta = i_external_count_pin;
    st_nxt.pin_sync = st_r.pin_meta;
    st_nxt.pin_prev = st_r.pin_sync;
    ovf_set = 1'b0;

    // Counter and flags on tick
    if (timer_tick) begin
      st_nxt.block_match = 1'b0;
      if (match_a) begin
        st_nxt.match_flag_a = 1'b1;
      end
      if (match_b) begin
        st_nxt.match_flag_b = 1'b1;
      end
      if (!pwm_mode) begin
        if (waveform_mode == WGM_CTC && at_top) begin
          st_nxt.counter_value = COUNT_BOTTOM;
        end else begin
          st_nxt.counter_value = st_r.counter_value + 8'h01;
        end
        if (at_max) begin
          ovf_set = 1'b1;
        end
      end else if (fast_mode) begin
        st_nxt.counter_value = at_top ? COUNT_BOTTOM : st_r.counter_value + 8'h01;
        if (at_top) begin
          ovf_set = 1'b1;
          st_nxt.compare_value_a = st_r.buffer_a;
          st_nxt.compare_value_b = st_r.buffer_b;
        end
      end else begin
        // Phase correct: reverse at top and bottom
        if (st_r.count_down) begin
          if (at_bottom) begin
            st_nxt.count_down = 1'b0;
            st_nxt.counter_value = st_r.counter_value + 8'h01;
            ovf_set = 1'b1;
          end else begin
            st_nxt.counter_value = st_r.counter_value - 8'h01;
          end
        end else if (at_top) begin
          st_nxt.count_down = 1'b1;
          st_nxt.counter_value = st_r.counter_value - 8'h01;
          st_nxt.compare_value_a = st_r.buffer_a;
          st_nxt.compare_value_b = st_r.buffer_b;
        end else begin
          st_nxt.counter_value = st_r.counter_value + 8'h01;
        end
      end
    end

    // Interrupt service clears
    if (i_ack_overflow) begin
      st_nxt.overflow_flag = 1'b0;
    end
    if (i_ack_match_a) begin
      st_nxt.match_flag_a = 1'b0;
    end
    if (i_ack_match_b) begin
      st_nxt.match_flag_b = 1'b0;
    end

    // Register writes; counter write last so it wins
    if (i_req.we) begin
      unique case (i_req.addr)
        ADDR_CONTROL_A: begin
          st_nxt.timer_control_a = i_req.wdata;
        end
        ADDR_CONTROL_B: begin
          st_nxt.clock_select = i_req.wdata[CS_POS+2 -: 3];
          st_nxt.waveform_mode_bit2 = i_req.wdata[WGM_HI_POS];
        end
        ADDR_COUNTER: begin
          st_nxt.counter_value = i_req.wdata;
          st_nxt.block_match = 1'b1;
        end
        ADDR_COMPARE_A: begin
          if (pwm_mode) begin
            st_nxt.buffer_a = i_req.wdata;
          end else begin
            st_nxt.compare_value_a = i_req.wdata;
            st_nxt.buffer_a = i_req.wdata;
          end
        end
        ADDR_COMPARE_B: begin
          if (pwm_mode) begin
            st_nxt.buffer_b = i_req.wdata;
          end else begin
            st_nxt.compare_value_b = i_req.wdata;
            st_nxt.buffer_b = i_req.wdata;
          end
        end
        ADDR_MASK: begin
          st_nxt.timer_mask_reg = i_req.wdata[MATCH_B_POS:OVF_POS];
        end
        ADDR_FLAG: begin
          // Write one clears, but a same-cycle set wins
          if (i_req.wdata[OVF_POS]) begin
            st_nxt.overflow_flag = 1'b0;
          end
          if (i_req.wdata[MATCH_A_POS] && !(timer_tick && match_a)) begin
            st_nxt.match_flag_a = 1'b0;
          end
          if (i_req.wdata[MATCH_B_POS] && !(timer_tick && match_b)) begin
            st_nxt.match_flag_b = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (timer_tick && match_a) begin
      st_nxt.match_flag_a = 1'b1;
    end
    if (timer_tick && match_b) begin
      st_nxt.match_flag_b = 1'b1;
    end
    // Overflow set also beats service and write-one clears
    if (ovf_set) begin
      st_nxt.overflow_flag = 1'b1;
    end

    // Read data, one cycle later
    st_nxt.rdata = RESET_BYTE;
    if (i_req.re) begin
      unique case (i_req.addr)
        ADDR_CONTROL_A: st_nxt.rdata = st_r.timer_control_a;
        ADDR_CONTROL_B: st_nxt.rdata = {4'h0, st_r.waveform_mode_bit2, st_r.clock_select};
        ADDR_COUNTER:   st_nxt.rdata = st_r.counter_value;
        ADDR_COMPARE_A: st_nxt.rdata = pwm_mode ? st_r.buffer_a : st_r.compare_value_a;
        ADDR_COMPARE_B: st_nxt.rdata = pwm_mode ? st_r.buffer_b : st_r.compare_value_b;
        ADDR_MASK:      st_nxt.rdata = {5'h00, st_r.timer_mask_reg};
        ADDR_FLAG:      st_nxt.rdata = {5'h00, st_r.match_flag_b, st_r.match_flag_a,
                                        st_r.overflow_flag};
        default:        st_nxt.rdata = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  compare_output_unit u_out_a (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_tick      (timer_tick),
    .i_pwm       (pwm_mode),
    .i_fast      (fast_mode),
    .i_up        (!st_r.count_down),
    .i_at_bottom (at_bottom),
    .i_at_top    (at_top),
    .i_ctx       (ctx_a),
    .o_level     (o_compare_output_a)
  );

  compare_output_unit u_out_b (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_tick      (timer_tick),
    .i_pwm       (pwm_mode),
    .i_fast      (fast_mode),
    .i_up        (!st_r.count_down),
    .i_at_bottom (at_bottom),
    .i_at_top    (at_top),
    .i_ctx       (ctx_b),
    .o_level     (o_compare_output_b)
  );

  assign o_rdata = st_r.rdata;
  assign o_irq_overflow = st_r.overflow_flag & st_r.timer_mask_reg[OVF_POS];
  assign o_irq_match_a  = st_r.match_flag_a & st_r.timer_mask_reg[MATCH_A_POS];
  assign o_irq_match_b  = st_r.match_flag_b & st_r.timer_mask_reg[MATCH_B_POS];
  assign o_compare_output_en_a = st_r.timer_control_a[COM_A_POS+1 -: 2] != COM_NONE;
  assign o_compare_output_en_b = st_r.timer_control_a[COM_B_POS+1 -: 2] != COM_NONE;

endmodule : timer8_counter_compare_core

// ==== verification/timer8_core_chk.sv ====
`timescale 1ns/10ps
module timer8_core_chk (
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_reset,
  // Register port
  input  wire timer8_pkg::reg_req_t i_req,
  input  wire logic [7:0]           o_rdata,
  input  wire logic                 i_ack_match_a,
  // Outputs under watch
  input  wire logic                 o_irq_overflow,
  input  wire logic                 o_irq_match_a,
  input  wire logic                 o_irq_match_b,
  input  wire logic                 o_compare_output_a,
  input  wire logic                 o_compare_output_en_a,
  input  wire logic                 o_compare_output_en_b
);
  import timer8_pkg::*;

  logic [7:0] mask_r;
  logic [7:0] cta_r;
  logic [7:0] ctb_r;
  logic [1:0] stop_cnt_r;
  logic       stop_ok;
  logic       wr_ctb;

  // Three stopped cycles flush any tick still in the pin synchroniser
  assign stop_ok = (stop_cnt_r == 2'h3) && (ctb_r[2:0] == CS_STOP);
  assign wr_ctb  = i_req.we && (i_req.addr == ADDR_CONTROL_B);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      mask_r     <= 8'h00;
      cta_r      <= 8'h00;
      ctb_r      <= 8'h00;
      stop_cnt_r <= 2'h0;
    end else begin
      if (i_req.we && i_req.addr == ADDR_MASK) mask_r <= i_req.wdata;
      if (i_req.we && i_req.addr == ADDR_CONTROL_A) cta_r <= i_req.wdata;
      if (wr_ctb) ctb_r <= i_req.wdata;
      if (ctb_r[2:0] != CS_STOP) stop_cnt_r <= 2'h0;
      else if (stop_cnt_r != 2'h3) stop_cnt_r <= stop_cnt_r + 2'h1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_rdata_idle: assert property (!$past(i_req.re) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_enable_a: assert property (i_req.we && i_req.addr == ADDR_CONTROL_A
    |=> o_compare_output_en_a == ($past(i_req.wdata[7:6]) != COM_NONE)) else $error("enable a wrong");
  a_enable_b: assert property (i_req.we && i_req.addr == ADDR_CONTROL_A
    |=> o_compare_output_en_b == ($past(i_req.wdata[5:4]) != COM_NONE)) else $error("enable b wrong");
  a_mask_ovf: assert property (!mask_r[OVF_POS] |-> !o_irq_overflow)
    else $error("masked overflow request seen");
  a_mask_match_a: assert property (!mask_r[MATCH_A_POS] |-> !o_irq_match_a)
    else $error("masked match a request seen");
  a_stop_no_ovf: assert property (stop_ok && $stable(mask_r) |-> !$rose(o_irq_overflow))
    else $error("overflow while stopped");
  a_ack_clear_a: assert property (stop_ok && i_ack_match_a |=> !o_irq_match_a)
    else $error("match a not cleared by service");
  a_w1c_match_b: assert property (stop_ok && i_req.we && i_req.addr == ADDR_FLAG
    && i_req.wdata[MATCH_B_POS] |=> !o_irq_match_b) else $error("match b not cleared by write");
  a_force_no_flag: assert property (stop_ok && wr_ctb && i_req.wdata[FORCE_A_POS]
    && i_req.wdata[2:0] == CS_STOP |=> !$rose(o_irq_match_a)) else $error("force set flag");
  a_force_toggle: assert property (stop_ok && wr_ctb && i_req.wdata[FORCE_A_POS]
    && i_req.wdata[2:0] == CS_STOP && !i_req.wdata[WGM_HI_POS] && cta_r[7:6] == COM_TOGGLE
    && (cta_r[1:0] == 2'h0 || cta_r[1:0] == 2'h2) |-> ##[1:2] $changed(o_compare_output_a))
    else $error("force did not toggle output a");

  c_overflow: cover property (o_irq_overflow);
  c_match_b: cover property ($rose(o_irq_match_b));
  c_output_a: cover property ($changed(o_compare_output_a));
endmodule : timer8_core_chk

bind timer8_counter_compare_core timer8_core_chk i_timer8_core_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(i_req), .o_rdata(o_rdata),
  .i_ack_match_a(i_ack_match_a), .o_irq_overflow(o_irq_overflow),
  .o_irq_match_a(o_irq_match_a), .o_irq_match_b(o_irq_match_b),
  .o_compare_output_a(o_compare_output_a), .o_compare_output_en_a(o_compare_output_en_a),
  .o_compare_output_en_b(o_compare_output_en_b)
);

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import timer8_pkg::*;

  logic       clk_sys = 1'b0;
  logic       reset   = 1'b1;
  reg_req_t   req     = '0;
  logic       ptick   = 1'b0;
  logic       ext_pin = 1'b0;
  logic       ack_ovf = 1'b0;
  logic       ack_a   = 1'b0;
  logic       ack_b   = 1'b0;
  logic [7:0] rdata;
  logic       irq_ovf, irq_a, irq_b, out_a, out_b, en_a, en_b;
  int         n_mismatch = 0;
  int         checks     = 0;

  always #12.5 clk_sys = ~clk_sys;

  timer8_counter_compare_core i_timer8_counter_compare_core (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_req(req), .o_rdata(rdata),
    .i_prescaled_tick(ptick), .i_external_count_pin(ext_pin),
    .i_ack_overflow(ack_ovf), .i_ack_match_a(ack_a), .i_ack_match_b(ack_b),
    .o_irq_overflow(irq_ovf), .o_irq_match_a(irq_a), .o_irq_match_b(irq_b),
    .o_compare_output_a(out_a), .o_compare_output_b(out_b),
    .o_compare_output_en_a(en_a), .o_compare_output_en_b(en_b)
  );

  task automatic give_verdict;
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask : wr

  // Read data live only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk_sys);
    req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    chk(rdata, exp, msg);
  endtask : rd

  task automatic tick_n(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ptick <= 1'b1;
      @(posedge clk_sys);
      ptick <= 1'b0;
    end
  endtask : tick_n

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic s_reset_and_access;
    chk({1'b0, irq_ovf, irq_a, irq_b, out_a, out_b, en_a, en_b}, 8'h00, "outputs after reset");
    for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00, "reset value");
    wr(ADDR_COUNTER, 8'hA5);
    rd(ADDR_COUNTER, 8'hA5, "counter write");
    wr(ADDR_COMPARE_A, 8'h3C);
    rd(ADDR_COMPARE_A, 8'h3C, "compare a");
    wr(ADDR_COMPARE_B, 8'hC3);
    rd(ADDR_COMPARE_B, 8'hC3, "compare b");
    wr(ADDR_MASK, 8'h07);
    rd(ADDR_MASK, 8'h07, "mask");
    wr(ADDR_COUNTER, 8'h20);
    tick_n(3);
    rd(ADDR_COUNTER, 8'h20, "stopped counter");
  endtask : s_reset_and_access

  task automatic s_external;
    logic lvl;
    for (int i = 0; i < 2; i++) begin
      lvl = (i == 1);
      ext_pin <= lvl;
      idle(8);
      wr(ADDR_CONTROL_B, (i == 1) ? {5'h00, CS_EXT_FALL} : {5'h00, CS_EXT_RISE});
      wr(ADDR_COUNTER, 8'h50);
      ext_pin <= !lvl;
      idle(8);
      rd(ADDR_COUNTER, 8'h51, "active pin edge");
      ext_pin <= lvl;
      idle(8);
      rd(ADDR_COUNTER, 8'h51, "inactive pin edge");
      wr(ADDR_CONTROL_B, 8'h00);
    end
  endtask : s_external

  task automatic s_overflow;
    wr(ADDR_CONTROL_B, 8'h01);
    wr(ADDR_COUNTER, 8'hFE);
    tick_n(1);
    rd(ADDR_COUNTER, 8'hFF, "count up");
    chk(irq_ovf, 1'b0, "early overflow");
    tick_n(1);
    rd(ADDR_COUNTER, 8'h00, "wrap");
    chk(irq_ovf, 1'b1, "overflow request");
    @(posedge clk_sys);
    ack_ovf <= 1'b1;
    @(posedge clk_sys);
    ack_ovf <= 1'b0;
    idle(1);
    chk(irq_ovf, 1'b0, "overflow serviced");
  endtask : s_overflow

  task automatic s_match;
    wr(ADDR_COMPARE_A, 8'h10);
    wr(ADDR_COUNTER, 8'h0F);
    tick_n(1);
    idle(1);
    chk(irq_a, 1'b0, "flag before next tick");
    tick_n(1);
    idle(1);
    chk(irq_a, 1'b1, "match a flag");
    wr(ADDR_FLAG, 8'h02);
    #1;
    chk(irq_a, 1'b0, "write one clears");
    // Counter written equal to compare: next tick must not flag
    wr(ADDR_COUNTER, 8'h10);
    tick_n(2);
    idle(1);
    chk(irq_a, 1'b0, "match blocked");
    @(posedge clk_sys);
    req <= '{we: 1'b1, re: 1'b0, addr: ADDR_COUNTER, wdata: 8'h40};
    ptick <= 1'b1;
    @(posedge clk_sys);
    req <= '0;
    ptick <= 1'b0;
    rd(ADDR_COUNTER, 8'h40, "write beats count");
  endtask : s_match

  task automatic s_clear_on_match;
    wr(ADDR_CONTROL_A, {6'h00, WGM_CTC[1:0]});
    wr(ADDR_COMPARE_A, 8'h12);
    wr(ADDR_COMPARE_B, 8'h12);
    wr(ADDR_COUNTER, 8'h11);
    tick_n(1);
    rd(ADDR_COUNTER, 8'h12, "reach top");
    tick_n(1);
    rd(ADDR_COUNTER, 8'h00, "clear on match");
    chk(irq_a, 1'b1, "top flag");
    chk(irq_b, 1'b1, "top flag b");
    wr(ADDR_CONTROL_B, 8'h00);
    idle(3);
    @(posedge clk_sys);
    ack_a <= 1'b1;
    ack_b <= 1'b1;
    @(posedge clk_sys);
    ack_a <= 1'b0;
    ack_b <= 1'b0;
    idle(1);
    chk(irq_a, 1'b0, "service clears");
    chk(irq_b, 1'b0, "service clears b");
  endtask : s_clear_on_match

  task automatic s_force;
    wr(ADDR_CONTROL_A, 8'h50);
    #1;
    chk({en_a, out_a}, 8'h02, "enable without action");
    wr(ADDR_CONTROL_B, 8'hC0);
    idle(2);
    chk({irq_a, out_a}, 8'h01, "forced toggle");
    chk({irq_b, out_b}, 8'h01, "forced toggle b");
    rd(ADDR_COUNTER, 8'h00, "force leaves counter");
    wr(ADDR_CONTROL_A, 8'h53);
    wr(ADDR_CONTROL_B, 8'hC0);
    idle(2);
    chk(out_a, 1'b1, "force ignored in pwm");
    chk(out_b, 1'b1, "force b ignored in pwm");
  endtask : s_force

  task automatic s_buffer;
    wr(ADDR_CONTROL_A, 8'h00);
    wr(ADDR_COMPARE_B, 8'h20);
    wr(ADDR_CONTROL_A, {6'h00, WGM_FAST_MAX[1:0]});
    wr(ADDR_COMPARE_B, 8'h30);
    rd(ADDR_COMPARE_B, 8'h30, "buffer read");
    wr(ADDR_CONTROL_B, 8'h01);
    wr(ADDR_COUNTER, 8'h1F);
    tick_n(2);
    idle(1);
    chk(irq_b, 1'b1, "active value kept mid period");
    wr(ADDR_CONTROL_B, 8'h00);
    idle(3);
    wr(ADDR_FLAG, 8'h04);
    #1;
    chk(irq_b, 1'b0, "write one clears b");
  endtask : s_buffer

  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    idle(1);
    s_reset_and_access();
    s_external();
    s_overflow();
    s_match();
    s_clear_on_match();
    s_force();
    s_buffer();
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
